/* verilog/wce_pkg.sv */
package wce_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CMD_W = 16;
  localparam int unsigned SEL_W = 5;
  localparam int unsigned CAL_POINTS = 8;
  localparam int unsigned THR_COUNT = 6;
  localparam logic [3:0] CAL_MAX = 4'h8;
  // Command codes carried in the command register.
  localparam logic [15:0] CMD_NONE = 16'h0000;
  localparam logic [15:0] CMD_TARE_RD = 16'h0057;
  localparam logic [15:0] CMD_TARE_WR = 16'h0058;
  localparam logic [15:0] CMD_SP1_RD = 16'h005a;
  localparam logic [15:0] CMD_SP2_RD = 16'h005b;
  localparam logic [15:0] CMD_SP3_RD = 16'h005c;
  localparam logic [15:0] CMD_SP1_WR = 16'h005d;
  localparam logic [15:0] CMD_SP2_WR = 16'h005e;
  localparam logic [15:0] CMD_SP3_WR = 16'h005f;
  localparam logic [15:0] CMD_SAVE = 16'h0063;
  localparam logic [15:0] CMD_CAL_ZERO = 16'h0064;
  localparam logic [15:0] CMD_CAL_FIRST = 16'h0065;
  localparam logic [15:0] CMD_SAMPLE_RD = 16'h0066;
  localparam logic [15:0] CMD_SAMPLE_WR = 16'h0067;
  localparam logic [15:0] CMD_CAL_CANCEL = 16'h0068;
  localparam logic [15:0] CMD_CAL_ADD = 16'h006a;
  localparam logic [15:0] CMD_ID_SEND = 16'h0078;
  localparam logic [15:0] CMD_PASS_SEND = 16'h0079;
  localparam logic [15:0] CMD_SEED_RD = 16'h007a;
  localparam logic [15:0] CMD_KEY_RD = 16'h007b;
  localparam logic [15:0] CMD_KEY_WR = 16'h007c;
  localparam logic [15:0] CMD_TARE_ON = 16'h0082;
  // Cyclic module selects.
  localparam logic [4:0] MOD_GROSS = 5'h00;
  localparam logic [4:0] MOD_NET = 5'h01;
  localparam logic [4:0] MOD_PEAK = 5'h02;
  localparam logic [4:0] MOD_SP1 = 5'h03;
  localparam logic [4:0] MOD_HY3 = 5'h08;
  localparam logic [4:0] MOD_DIV = 5'h09;
  localparam logic [4:0] MOD_UNIT = 5'h0a;
  localparam logic [4:0] MOD_INPUTS = 5'h0b;
  localparam logic [4:0] MOD_STATUS = 5'h0c;
  localparam logic [4:0] MOD_SAMPLE = 5'h0d;
  localparam logic [4:0] MOD_SEED = 5'h0e;
  localparam logic [4:0] MOD_KEY = 5'h0f;
  localparam logic [4:0] MOD_TARE = 5'h10;
  // Status bit positions.
  localparam int unsigned ST_GROSS_NEG = 7;
  localparam int unsigned ST_NET_NEG = 8;
  localparam int unsigned ST_PEAK_NEG = 9;
  localparam int unsigned ST_WR_ERR = 13;
  // Special module write values.
  localparam logic [31:0] W_IGNORE = 32'h00000000;
  localparam logic [31:0] W_ZERO = 32'h80000000;
  // Division code table shape.
  localparam logic [4:0] DIV_LAST_INT = 5'h06;
  localparam logic [4:0] DIV_MAX = 5'h12;
  localparam logic [4:0] DIV_GROUP = 5'h03;
  localparam logic [15:0] SEED_RESET = 16'h0000;
  typedef enum logic [2:0] {
    WCE_IDLE = 3'b000,
    WCE_GAP = 3'b001,
    WCE_ISSUE = 3'b010,
    WCE_SETTLE = 3'b011,
    WCE_CAPTURE = 3'b100
  } wce_mstate_type;
endpackage

/* verilog/wce_if.sv */
`timescale 1ns/10ps
interface wce_if;
  logic [15:0] cmd;
  logic [31:0] wr_xchg;
  logic [31:0] rd_xchg;
  logic mod_wr;
  logic [4:0] mod_sel;
  logic [31:0] mod_wdata;
  logic [4:0] mod_rsel;
  logic [31:0] mod_rdata;
  modport device (input cmd, input wr_xchg, input mod_wr, input mod_sel, input mod_wdata,
    input mod_rsel, output rd_xchg, output mod_rdata);
  modport master (output cmd, output wr_xchg, output mod_wr, output mod_sel,
    output mod_wdata, output mod_rsel, input rd_xchg, input mod_rdata);
endinterface

/* verilog/wce_device.sv */
`timescale 1ns/10ps
// Overview of operation
// (RULE1) Setpoints are unsigned integers, decimals implied
// (RULE2) Setpoints volatile; command 99 saves them
// (RULE3) Command 130 applies the loaded preset tare
// (RULE4) Master sends code, 120, reads seed, password, 121
// (RULE5) Seed reads zero once access granted
// (RULE6) Reset clears qualified access
// (RULE7) Calibration commands need qualified access
// (RULE8) Command 100 captures present weight as zero
// (RULE9) Master loads sample by 103 or module
// (RULE10) 101 restarts points; 106 appends a point
// (RULE11) Eight points max; no duplicate, no zero
// (RULE12) Stored point clears the sample weight
// (RULE13) 104 drops real calibration, keeps zero
// (RULE14) Sample taken as signed 32-bit value
// (RULE15) Cyclic modules with documented sizes and access
// (RULE16) Module write zero ignored; MSB-only stores zero; tare and key module writes store the word unchanged
// (RULE17) Out-of-range setpoint rejected, sets write error
// (RULE18) Weights reported as magnitudes, signs in status
// (RULE19) Division code 0 to 18 with decimals
// (RULE20) Read after command; load exchange before write
// (RULE21) Act only when the command value changes
// (RULE22) Unqualified protected commands change nothing
// (RULE23) Write error stays until an accepted write
module wce_device
  import wce_pkg::*;
#(
  parameter logic [15:0] PASS_KEY = 16'h3c5a
)(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  wce_if.device bus,
  input wire logic [31:0] weight_raw_i,
  input wire logic [31:0] full_scale_i,
  input wire logic [4:0] division_code_i,
  input wire logic [15:0] unit_code_i,
  input wire logic [15:0] inputs_i,
  input wire logic [15:0] status_flags_i,
  output logic nvm_save_o,
  output logic tare_on_o,
  output logic access_granted_o,
  output logic real_cal_o,
  output logic [3:0] cal_count_o,
  output logic [2:0] decimals_o
);
  // The default of PASS_KEY is arbitrary.
  logic [15:0] cmd_prev;
  logic [31:0] thr [THR_COUNT];
  logic [31:0] sample;
  logic [31:0] tare_val;
  logic [31:0] tare_applied;
  logic [31:0] cal_zero;
  logic [31:0] pt_sample [CAL_POINTS];
  logic [31:0] pt_raw [CAL_POINTS];
  logic [15:0] user_key;
  logic [15:0] user_id;
  logic [15:0] seed;
  logic [15:0] seed_gen;
  logic granted;
  logic wr_err;
  logic signed [31:0] gross_s;
  logic signed [31:0] net_s;
  logic signed [31:0] peak_s;
  logic [CAL_POINTS-1:0] dup_hit;
  logic is_new;
  logic do_cal;
  logic cal_ok;
  logic thr_mod;
  logic [2:0] thr_mod_idx;
  logic [31:0] mod_val;
  logic mod_val_ok;
  logic thr_cmd;
  logic [2:0] thr_cmd_idx;
  logic cmd_val_ok;
  logic [15:0] status_word;
  logic [31:0] gross_mag;
  logic [31:0] net_mag;
  logic [31:0] peak_mag;

  function automatic logic in_range(input logic [31:0] v, input logic [31:0] fs);
    in_range = !v[31] && (v <= fs);
  endfunction

  assign is_new = (bus.cmd != cmd_prev) && (bus.cmd != CMD_NONE); // (RULE21)
  assign do_cal = is_new && granted; // (RULE7) (RULE22)

  // Setpoint and sample module writes: the all-zero word is a no-write, the MSB-only word means zero.
  assign mod_val = (bus.mod_wdata == W_ZERO) ? 32'h00000000 : bus.mod_wdata; // (RULE16)
  assign thr_mod = bus.mod_wr && (bus.mod_sel >= MOD_SP1) && (bus.mod_sel <= MOD_HY3)
    && (bus.mod_wdata != W_IGNORE); // (RULE16)
  assign thr_mod_idx = 3'(bus.mod_sel - MOD_SP1);
  assign mod_val_ok = in_range(mod_val, full_scale_i); // (RULE17)
  assign thr_cmd = is_new && (bus.cmd >= CMD_SP1_WR) && (bus.cmd <= CMD_SP3_WR);
  assign thr_cmd_idx = 3'(bus.cmd - CMD_SP1_WR);
  // Over the command path zero is outside the open lower bound.
  assign cmd_val_ok = in_range(bus.wr_xchg, full_scale_i) && (bus.wr_xchg != 32'h00000000);

  genvar gi;
  generate
    for (gi = 0; gi < CAL_POINTS; gi++)
    begin : g_dup
      assign dup_hit[gi] = (4'(gi) < cal_count_o) && (pt_sample[gi] == sample); // (RULE11)
    end
  endgenerate

  assign cal_ok = do_cal && (sample != 32'h00000000)
    && ((bus.cmd == CMD_CAL_FIRST)
    || ((bus.cmd == CMD_CAL_ADD) && (dup_hit == '0) && (cal_count_o < CAL_MAX))); // (RULE11)

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      cmd_prev <= CMD_NONE;
    else if (ce_i)
      cmd_prev <= bus.cmd;
  end

  // Setpoints and hystereses live only here and reset to zero at power-up.
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < THR_COUNT; i++)
        thr[i] <= 32'h00000000; // (RULE2)
    end
    else if (ce_i)
    begin
      if (thr_mod && mod_val_ok)
        thr[thr_mod_idx] <= mod_val; // (RULE1)
      if (thr_cmd && cmd_val_ok)
        thr[thr_cmd_idx] <= bus.wr_xchg;
    end
  end

  // A rejection in the same cycle as an acceptance leaves the error set.
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      wr_err <= 1'b0;
    else if (ce_i)
    begin
      if ((thr_mod && !mod_val_ok) || (thr_cmd && !cmd_val_ok))
        wr_err <= 1'b1; // (RULE17)
      else if (thr_mod || thr_cmd)
        wr_err <= 1'b0; // (RULE23)
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      nvm_save_o <= 1'b0;
    else if (ce_i)
      nvm_save_o <= is_new && (bus.cmd == CMD_SAVE); // (RULE2)
  end

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      tare_val <= 32'h00000000;
      tare_applied <= 32'h00000000;
      tare_on_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (bus.mod_wr && (bus.mod_sel == MOD_TARE))
        tare_val <= bus.mod_wdata;
      if (is_new && (bus.cmd == CMD_TARE_WR))
        tare_val <= bus.wr_xchg;
      if (is_new && (bus.cmd == CMD_TARE_ON))
      begin
        tare_applied <= tare_val; // (RULE3)
        tare_on_o <= 1'b1;
      end
    end
  end

  // A fresh sample write in the cycle of a store wins over the clear.
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      sample <= 32'h00000000;
    else if (ce_i)
    begin
      if (cal_ok)
        sample <= 32'h00000000; // (RULE12)
      if (bus.mod_wr && (bus.mod_sel == MOD_SAMPLE) && (bus.mod_wdata != W_IGNORE))
        sample <= mod_val; // (RULE16)
      if (is_new && (bus.cmd == CMD_SAMPLE_WR))
        sample <= bus.wr_xchg; // (RULE14)
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      cal_zero <= 32'h00000000;
      cal_count_o <= 4'h0;
      for (int i = 0; i < CAL_POINTS; i++)
      begin
        pt_sample[i] <= 32'h00000000;
        pt_raw[i] <= 32'h00000000;
      end
    end
    else if (ce_i)
    begin
      if (do_cal && (bus.cmd == CMD_CAL_ZERO))
        cal_zero <= weight_raw_i; // (RULE8)
      if (do_cal && (bus.cmd == CMD_CAL_CANCEL))
        cal_count_o <= 4'h0; // (RULE13)
      if (cal_ok && (bus.cmd == CMD_CAL_FIRST))
      begin
        pt_sample[0] <= sample; // (RULE10)
        pt_raw[0] <= weight_raw_i;
        cal_count_o <= 4'h1;
      end
      else if (cal_ok)
      begin
        pt_sample[cal_count_o[2:0]] <= sample; // (RULE10)
        pt_raw[cal_count_o[2:0]] <= weight_raw_i;
        cal_count_o <= cal_count_o + 4'h1;
      end
    end
  end

  assign real_cal_o = (cal_count_o != 4'h0);

  // The seed source free-runs so each access attempt sees a different seed.
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      seed_gen <= 16'h0001;
    else if (ce_i)
      seed_gen <= {seed_gen[14:0], seed_gen[15] ^ seed_gen[13] ^ seed_gen[12] ^ seed_gen[10]};
  end

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      granted <= 1'b0; // (RULE6)
      seed <= SEED_RESET;
      user_key <= 16'h0000;
      user_id <= 16'h0000;
    end
    else if (ce_i)
    begin
      if (bus.mod_wr && (bus.mod_sel == MOD_KEY))
        user_key <= bus.mod_wdata[15:0];
      if (is_new && (bus.cmd == CMD_KEY_WR))
        user_key <= bus.wr_xchg[15:0];
      if (is_new && (bus.cmd == CMD_ID_SEND))
      begin
        user_id <= user_key;
        seed <= seed_gen;
        granted <= 1'b0;
      end
      if (is_new && (bus.cmd == CMD_PASS_SEND))
      begin
        if ((seed != 16'h0000) && (user_key == (seed ^ user_id ^ PASS_KEY)))
        begin
          granted <= 1'b1;
          seed <= 16'h0000; // (RULE5)
        end
        else
          granted <= 1'b0;
      end
    end
  end

  assign access_granted_o = granted;

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      gross_s <= 32'sh0;
      net_s <= 32'sh0;
      peak_s <= 32'sh0;
    end
    else if (ce_i)
    begin
      gross_s <= $signed(weight_raw_i - cal_zero);
      net_s <= $signed(weight_raw_i - cal_zero - tare_applied);
      if ($signed(weight_raw_i - cal_zero) > peak_s)
        peak_s <= $signed(weight_raw_i - cal_zero);
    end
  end

  assign gross_mag = gross_s[31] ? 32'(-gross_s) : gross_s; // (RULE18)
  assign net_mag = net_s[31] ? 32'(-net_s) : net_s;
  assign peak_mag = peak_s[31] ? 32'(-peak_s) : peak_s;

  always_comb
  begin
    status_word = status_flags_i;
    status_word[ST_GROSS_NEG] = gross_s[31]; // (RULE18)
    status_word[ST_NET_NEG] = net_s[31];
    status_word[ST_PEAK_NEG] = peak_s[31];
    status_word[ST_WR_ERR] = wr_err; // (RULE17)
  end

  always_comb
  begin
    if (division_code_i <= DIV_LAST_INT)
      decimals_o = 3'h0; // (RULE19)
    else if (division_code_i > DIV_MAX)
      decimals_o = 3'h4;
    else
      decimals_o = 3'((division_code_i - DIV_LAST_INT - 5'h01) / DIV_GROUP + 5'h01);
  end

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      bus.rd_xchg <= 32'h00000000;
    else if (ce_i && is_new)
    begin
      unique case (bus.cmd)
        CMD_TARE_RD: bus.rd_xchg <= tare_val; // (RULE20)
        CMD_SP1_RD: bus.rd_xchg <= thr[0];
        CMD_SP2_RD: bus.rd_xchg <= thr[1];
        CMD_SP3_RD: bus.rd_xchg <= thr[2];
        CMD_SAMPLE_RD: bus.rd_xchg <= sample;
        CMD_SEED_RD: bus.rd_xchg <= {16'h0000, seed};
        CMD_KEY_RD: bus.rd_xchg <= {16'h0000, user_key};
        default: bus.rd_xchg <= bus.rd_xchg;
      endcase
    end
  end

  // Write-only command module reads as zero.
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      bus.mod_rdata <= 32'h00000000;
    else if (ce_i)
    begin
      unique case (bus.mod_rsel)
        MOD_GROSS: bus.mod_rdata <= gross_mag; // (RULE15)
        MOD_NET: bus.mod_rdata <= net_mag;
        MOD_PEAK: bus.mod_rdata <= peak_mag;
        5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08:
          bus.mod_rdata <= thr[3'(bus.mod_rsel - MOD_SP1)];
        MOD_DIV: bus.mod_rdata <= {27'h0000000, division_code_i};
        MOD_UNIT: bus.mod_rdata <= {16'h0000, unit_code_i};
        MOD_INPUTS: bus.mod_rdata <= {16'h0000, inputs_i};
        MOD_STATUS: bus.mod_rdata <= {16'h0000, status_word};
        MOD_SAMPLE: bus.mod_rdata <= sample;
        MOD_SEED: bus.mod_rdata <= {16'h0000, seed};
        MOD_KEY: bus.mod_rdata <= {16'h0000, user_key};
        MOD_TARE: bus.mod_rdata <= tare_val;
        default: bus.mod_rdata <= 32'h00000000;
      endcase
    end
  end
endmodule

/* verilog/wce_master.sv */
`timescale 1ns/10ps
module wce_master
  import wce_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  wce_if.master bus,
  input wire logic req_valid_i,
  input wire logic [15:0] req_cmd_i,
  input wire logic [31:0] req_data_i,
  output logic req_ready_o,
  output logic resp_valid_o,
  output logic [31:0] resp_data_o,
  input wire logic mod_wr_i,
  input wire logic [4:0] mod_sel_i,
  input wire logic [31:0] mod_wdata_i,
  input wire logic [4:0] mod_rsel_i,
  output logic [31:0] mod_rdata_o
);
  wce_mstate_type state;
  logic [15:0] pend_cmd;

  assign req_ready_o = (state == WCE_IDLE);
  assign mod_rdata_o = bus.mod_rdata;

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      state <= WCE_IDLE;
      pend_cmd <= CMD_NONE;
      bus.cmd <= CMD_NONE;
      bus.wr_xchg <= 32'h00000000;
      resp_valid_o <= 1'b0;
      resp_data_o <= 32'h00000000;
    end
    else if (ce_i)
    begin
      resp_valid_o <= 1'b0;
      unique case (state)
        WCE_IDLE:
          if (req_valid_i)
          begin
            bus.wr_xchg <= req_data_i; // (RULE20)
            pend_cmd <= req_cmd_i;
            // A repeated code needs a zero between, or the device sees no change.
            if (req_cmd_i == bus.cmd)
            begin
              bus.cmd <= CMD_NONE; // (RULE21)
              state <= WCE_GAP;
            end
            else
              state <= WCE_ISSUE;
          end
        WCE_GAP:
          state <= WCE_ISSUE;
        WCE_ISSUE:
        begin
          bus.cmd <= pend_cmd; // (RULE4) (RULE9)
          state <= WCE_SETTLE;
        end
        WCE_SETTLE:
          state <= WCE_CAPTURE;
        WCE_CAPTURE:
        begin
          resp_data_o <= bus.rd_xchg; // (RULE20)
          resp_valid_o <= 1'b1;
          state <= WCE_IDLE;
        end
        default:
          state <= WCE_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      bus.mod_wr <= 1'b0;
      bus.mod_sel <= 5'h00;
      bus.mod_wdata <= 32'h00000000;
      bus.mod_rsel <= 5'h00;
    end
    else if (ce_i)
    begin
      bus.mod_wr <= mod_wr_i; // (RULE16)
      bus.mod_sel <= mod_sel_i;
      bus.mod_wdata <= mod_wdata_i;
      bus.mod_rsel <= mod_rsel_i;
    end
  end
endmodule

/* testbench/wce_monitor.sv */
`timescale 1ns/10ps
module wce_monitor
  import wce_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [15:0] cmd,
  input wire logic [4:0] mod_rsel,
  input wire logic [31:0] mod_rdata,
  input wire logic [4:0] division_code_i,
  input wire logic nvm_save_o,
  input wire logic tare_on_o,
  input wire logic access_granted_o,
  input wire logic real_cal_o,
  input wire logic [3:0] cal_count_o,
  input wire logic [2:0] decimals_o
);
  logic [2:0] exp_dec;
  always_comb
  begin
    // Expected decimals follow the code table groups, not the arithmetic form.
    if (division_code_i <= DIV_LAST_INT)
      exp_dec = 3'h0;
    else if (division_code_i < 5'h0a)
      exp_dec = 3'h1;
    else if (division_code_i < 5'h0d)
      exp_dec = 3'h2;
    else if (division_code_i < 5'h10)
      exp_dec = 3'h3;
    else
      exp_dec = 3'h4;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  property p_save_on_change;
    nvm_save_o |-> $past(cmd) == CMD_SAVE && $past(cmd, 2) != CMD_SAVE;
  endproperty
  a_save_on_change: assert property (p_save_on_change)
    else $error("save pulse without a fresh save code");
  property p_save_taken;
    ce_i && $past(ce_i) && cmd == CMD_SAVE && $past(cmd) != CMD_SAVE |=> nvm_save_o;
  endproperty
  a_save_taken: assert property (p_save_taken)
    else $error("save code gave no save pulse");
  property p_tare_on;
    ce_i && $past(ce_i) && cmd == CMD_TARE_ON && $past(cmd) != CMD_TARE_ON |=> tare_on_o;
  endproperty
  a_tare_on: assert property (p_tare_on)
    else $error("tare enable code did not apply tare");
  property p_cal_max;
    cal_count_o <= CAL_MAX;
  endproperty
  a_cal_max: assert property (p_cal_max)
    else $error("too many calibration points");
  property p_cal_cancel;
    ce_i && access_granted_o && cmd == CMD_CAL_CANCEL && $past(cmd) != CMD_CAL_CANCEL
      |=> cal_count_o == 4'h0 && !real_cal_o;
  endproperty
  a_cal_cancel: assert property (p_cal_cancel)
    else $error("calibration cancel left points");
  property p_cal_guard;
    $past(nrst_i) && cal_count_o != $past(cal_count_o) |-> $past(access_granted_o);
  endproperty
  a_cal_guard: assert property (p_cal_guard)
    else $error("calibration changed without access");
  property p_grant_cause;
    $rose(access_granted_o) |-> $past(cmd) == CMD_PASS_SEND;
  endproperty
  a_grant_cause: assert property (p_grant_cause)
    else $error("access granted without password code");
  property p_access_reset;
    !$past(nrst_i) |-> !access_granted_o;
  endproperty
  a_access_reset: assert property (p_access_reset)
    else $error("access survived reset");
  property p_decimals;
    decimals_o == exp_dec;
  endproperty
  a_decimals: assert property (p_decimals)
    else $error("decimals do not match division code");
  property p_div_module;
    ce_i && mod_rsel == MOD_DIV |=> mod_rdata == {27'h0, $past(division_code_i)};
  endproperty
  a_div_module: assert property (p_div_module)
    else $error("division module read wrong");
endmodule

/* testbench/testbench.sv */
`timescale 1ns/10ps
module testbench
  import wce_pkg::*;
;
  typedef struct packed {
    logic [31:0] v;
    logic k;
  } wce_note_type;
  localparam logic [15:0] KEY = 16'h3c5a;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic ce_i = 1'b1;
  logic req_valid_i = 1'b0;
  logic [15:0] req_cmd_i = 16'h0000;
  logic [31:0] req_data_i = 32'h00000000;
  logic mod_wr_i = 1'b0;
  logic [4:0] mod_sel_i = 5'h00;
  logic [31:0] mod_wdata_i = 32'h00000000;
  logic [4:0] mod_rsel_i = 5'h00;
  logic [31:0] weight_raw_i = 32'h00001388;
  logic [4:0] division_code_i = 5'h00;
  logic req_ready_o, resp_valid_o, nvm_save_o, tare_on_o, access_granted_o, real_cal_o;
  logic [31:0] resp_data_o, mod_rdata_o, last_rsp, rd;
  logic [3:0] cal_count_o;
  logic [2:0] decimals_o;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  int saves = 0;
  integer seed = 32'h2e77ba64;
  wce_note_type notes[$];
  wce_note_type note;
  always #5 clock_i = ~clock_i;
  wce_if bus_if();
  wce_device #(.PASS_KEY(KEY)) i_wce_device (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .bus(bus_if.device), .weight_raw_i(weight_raw_i), .full_scale_i(32'h000186a0),
    .division_code_i(division_code_i), .unit_code_i(16'h0000), .inputs_i(16'h0003),
    .status_flags_i(16'h0000), .nvm_save_o(nvm_save_o), .tare_on_o(tare_on_o),
    .access_granted_o(access_granted_o), .real_cal_o(real_cal_o), .cal_count_o(cal_count_o),
    .decimals_o(decimals_o));
  wce_master i_wce_master (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .bus(bus_if.master),
    .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i), .req_data_i(req_data_i),
    .req_ready_o(req_ready_o), .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o),
    .mod_wr_i(mod_wr_i), .mod_sel_i(mod_sel_i), .mod_wdata_i(mod_wdata_i),
    .mod_rsel_i(mod_rsel_i), .mod_rdata_o(mod_rdata_o));
  wce_monitor i_wce_monitor (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .cmd(bus_if.cmd),
    .mod_rsel(bus_if.mod_rsel), .mod_rdata(bus_if.mod_rdata), .division_code_i(division_code_i),
    .nvm_save_o(nvm_save_o), .tare_on_o(tare_on_o), .access_granted_o(access_granted_o),
    .real_cal_o(real_cal_o), .cal_count_o(cal_count_o), .decimals_o(decimals_o));
  task automatic end_sim();
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
      err_total++;
    end
  endtask
  // Every request is answered; k low marks an answer whose data is not checked.
  task automatic cmd(input logic [15:0] c, input logic [31:0] d, input logic k,
    input logic [31:0] e);
    @(negedge clock_i);
    while (req_ready_o !== 1'b1) @(negedge clock_i);
    notes.push_back('{v: e, k: k});
    req_cmd_i = c;
    req_data_i = d;
    req_valid_i = 1'b1;
    @(negedge clock_i);
    req_valid_i = 1'b0;
    while (notes.size() != 0) @(negedge clock_i);
  endtask
  task automatic mwr(input logic [4:0] s, input logic [31:0] d);
    @(negedge clock_i);
    mod_wr_i = 1'b1;
    mod_sel_i = s;
    mod_wdata_i = d;
    @(negedge clock_i);
    mod_wr_i = 1'b0;
    repeat (2) @(negedge clock_i);
  endtask
  task automatic mrd(input logic [4:0] s);
    @(negedge clock_i);
    mod_rsel_i = s;
    repeat (3) @(negedge clock_i);
    rd = mod_rdata_o;
  endtask
  always @(posedge clock_i)
  begin
    cycles++;
    if (nvm_save_o === 1'b1)
      saves++;
    if (resp_valid_o === 1'b1)
    begin
      last_rsp = resp_data_o;
      note = notes.pop_front();
      if (note.k === 1'b1)
        chk(note.v, resp_data_o);
    end
    if (cycles == 6000)
    begin
      err_total++;
      end_sim();
    end
  end
  initial
  begin
    logic [31:0] sp;
    logic [31:0] s;
    repeat (3) @(negedge clock_i);
    nrst_i = 1'b1;
    for (int i = 0; i <= 20; i++)
    begin
      division_code_i = 5'(i);
      mrd(MOD_DIV);
      chk({27'h0, 5'(i)}, rd);
      chk(32'((i <= 6) ? 0 : (i > 18) ? 4 : (i - 4) / 3), {29'h0, decimals_o});
    end
    sp = 32'($unsigned($random(seed)) % 32'h000186a0) + 32'h1;
    cmd(CMD_SP1_WR, sp, 1'b0, 32'h0);
    cmd(CMD_SP1_RD, 32'h0, 1'b1, sp);
    cmd(CMD_SP1_WR, 32'h000186a1, 1'b0, 32'h0);
    cmd(CMD_SP1_RD, 32'h0, 1'b1, sp);
    mrd(MOD_STATUS);
    chk(32'h1, {31'h0, rd[ST_WR_ERR]});
    cmd(CMD_SP2_RD, 32'h0, 1'b0, 32'h0);
    mrd(MOD_STATUS);
    chk(32'h1, {31'h0, rd[ST_WR_ERR]});
    cmd(CMD_SP2_WR, sp, 1'b0, 32'h0);
    mrd(MOD_STATUS);
    chk(32'h0, {31'h0, rd[ST_WR_ERR]});
    mwr(MOD_SP1, W_IGNORE);
    cmd(CMD_SP1_RD, 32'h0, 1'b1, sp);
    mwr(MOD_SP1, W_ZERO);
    cmd(CMD_SP1_RD, 32'h0, 1'b1, 32'h0);
    cmd(CMD_SAVE, 32'h0, 1'b0, 32'h0);
    cmd(CMD_SAVE, 32'h0, 1'b0, 32'h0);
    chk(32'h2, 32'(saves));
    cmd(CMD_CAL_ZERO, 32'h0, 1'b0, 32'h0);
    cmd(CMD_SAMPLE_WR, 32'h00000010, 1'b0, 32'h0);
    cmd(CMD_CAL_FIRST, 32'h0, 1'b0, 32'h0);
    chk(32'h0, {28'h0, cal_count_o});
    mrd(MOD_NET);
    chk(32'h00001388, rd);
    cmd(CMD_KEY_WR, 32'h00000a5c, 1'b0, 32'h0);
    cmd(CMD_ID_SEND, 32'h0, 1'b0, 32'h0);
    cmd(CMD_SEED_RD, 32'h0, 1'b0, 32'h0);
    s = last_rsp;
    chk(32'h1, {31'h0, s != 32'h0});
    cmd(CMD_KEY_WR, {16'h0, s[15:0] ^ 16'h0a5c}, 1'b0, 32'h0);
    cmd(CMD_PASS_SEND, 32'h0, 1'b0, 32'h0);
    cmd(CMD_SEED_RD, 32'h0, 1'b1, s);
    cmd(CMD_KEY_WR, {16'h0, s[15:0] ^ 16'h0a5c ^ KEY}, 1'b0, 32'h0);
    cmd(CMD_PASS_SEND, 32'h0, 1'b0, 32'h0);
    cmd(CMD_SEED_RD, 32'h0, 1'b1, 32'h0);
    cmd(CMD_CAL_ZERO, 32'h0, 1'b0, 32'h0);
    mrd(MOD_NET);
    chk(32'h0, rd);
    cmd(CMD_SAMPLE_WR, 32'hffffffc8, 1'b0, 32'h0);
    cmd(CMD_SAMPLE_RD, 32'h0, 1'b1, 32'hffffffc8);
    cmd(CMD_CAL_FIRST, 32'h0, 1'b0, 32'h0);
    cmd(CMD_SAMPLE_RD, 32'h0, 1'b1, 32'h0);
    mwr(MOD_SAMPLE, 32'hffffffc8);
    cmd(CMD_CAL_ADD, 32'h0, 1'b0, 32'h0);
    chk(32'h1, {28'h0, cal_count_o});
    cmd(CMD_SAMPLE_RD, 32'h0, 1'b1, 32'hffffffc8);
    for (int k = 2; k <= 9; k++)
    begin
      s = $random(seed);
      cmd(CMD_SAMPLE_WR, {s[31:4], 4'(k)}, 1'b0, 32'h0);
      cmd(CMD_CAL_ADD, 32'h0, 1'b0, 32'h0);
      chk(32'((k > 8) ? 8 : k), {28'h0, cal_count_o});
    end
    cmd(CMD_CAL_FIRST, 32'h0, 1'b0, 32'h0);
    chk(32'h1, {28'h0, cal_count_o});
    cmd(CMD_CAL_ADD, 32'h0, 1'b0, 32'h0);
    chk(32'h1, {28'h0, cal_count_o});
    cmd(CMD_CAL_CANCEL, 32'h0, 1'b0, 32'h0);
    chk(32'h0, {27'h0, real_cal_o, cal_count_o});
    mrd(MOD_NET);
    chk(32'h0, rd);
    cmd(CMD_TARE_WR, 32'h00000064, 1'b0, 32'h0);
    cmd(CMD_TARE_RD, 32'h0, 1'b1, 32'h00000064);
    cmd(CMD_TARE_ON, 32'h0, 1'b0, 32'h0);
    mrd(MOD_NET);
    chk(32'h00000064, rd);
    mrd(MOD_STATUS);
    chk(32'h1, {31'h0, rd[ST_NET_NEG]});
    mrd(MOD_PEAK);
    chk(32'h00001388, rd);
    mrd(MOD_GROSS);
    chk(32'h0, rd);
    mrd(MOD_INPUTS);
    chk(32'h3, rd);
    mwr(MOD_TARE, 32'h00000123);
    mrd(MOD_TARE);
    chk(32'h00000123, rd);
    // With the enable low the module write must be lost on both ends.
    ce_i = 1'b0;
    mwr(MOD_TARE, 32'h00000456);
    ce_i = 1'b1;
    mrd(MOD_TARE);
    chk(32'h00000123, rd);
    mwr(MOD_KEY, 32'h0000beef);
    cmd(CMD_KEY_RD, 32'h0, 1'b1, 32'h0000beef);
    mwr(MOD_HY3, 32'h00000200);
    mrd(MOD_HY3);
    chk(32'h00000200, rd);
    mwr(MOD_HY3, 32'h7fffffff);
    mrd(MOD_STATUS);
    chk(32'h1, {31'h0, rd[ST_WR_ERR]});
    mrd(MOD_HY3);
    chk(32'h00000200, rd);
    nrst_i = 1'b0;
    repeat (3) @(negedge clock_i);
    nrst_i = 1'b1;
    @(negedge clock_i);
    chk(32'h0, {31'h0, access_granted_o});
    end_sim();
  end
endmodule
